// ===== design/measurement_io_sequencer.sv
// discrete i/o sequencer of the measurement unit with an axi4-lite register slave
// Behaviour
// - Judgment strobe rises only after the configured delay following judgment.
// - Result output high for OK, low for NG.
// - New start triggers are ignored while busy is high.
// - Busy is high from accepted start until image capture completes.
// - Internal mode with hold keeps measuring; only reporting changes.
// - Hold in internal I/O-request mode sends the preceding result once.
// - Hold in internal stream mode suppresses all result transmissions.
// - External trigger mode ignores the hold input completely.
// - Zero input sets or resets the measurement origin.
// - In offset-tilt measurement the zero input toggles the judgment criterion.
// - Either trigger input driven high starts a measurement.
// - Trigger inputs act only in external trigger mode.
// - Laser emission enabled while the laser pair is shorted.
// - Strobe delay setting ranges 1 to 999.
// - Strobe width setting ranges 1 to 999.
// - Low-voltage trigger starts on its rising edge, not its level.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module measurement_io_sequencer #(
  parameter int CYC_PER_MS   = mis_pkg::CYC_PER_MS,
  parameter int DEBOUNCE_CYC = mis_pkg::DEBOUNCE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // controller-side discrete inputs
  input  wire logic        start_in_high_volt,
  input  wire logic        start_in_low_volt,
  input  wire logic        hold_in,
  input  wire logic        zero_in,
  input  wire logic        laser_pair_shorted,
  // discrete outputs to the controller
  output logic             judgment_strobe,
  output logic             judgment_pass,
  output logic             capture_in_progress,
  // measurement core side
  input  wire logic        capture_done,
  input  wire logic        judge_done,
  input  wire logic        judge_ok,
  input  wire logic        result_valid,
  output logic             meas_start,
  output logic             laser_enable,
  output logic             origin_set,
  output logic             criterion_toggle,
  output logic             criterion_sel,
  output logic             report_send,
  output logic             report_resend_held,
  output logic             irq
);

  // ---------------- input conditioning ----------------
  logic [mis_pkg::IN_N-1:0] raw_in;
  logic [mis_pkg::IN_N-1:0] deb;
  logic [mis_pkg::IN_N-1:0] deb_prev_q;

  assign raw_in = {laser_pair_shorted, zero_in, hold_in, start_in_low_volt, start_in_high_volt};

  // filter keeps contact bounce from firing several starts
  mis_debounce #(
    .W      (mis_pkg::IN_N),
    .CYCLES (DEBOUNCE_CYC)
  ) u_debounce (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (raw_in),
    .clean   (deb)
  );

  // previous filtered levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deb_prev_q <= '0;
    end else begin
      deb_prev_q <= deb;
    end
  end

  // ---------------- registers ----------------
  logic [2:0]               ctrl_q;
  logic [9:0]               delay_q;
  logic [9:0]               width_q;
  logic [mis_pkg::IRQ_N-1:0] istat_q;
  logic [mis_pkg::IRQ_N-1:0] imask_q;
  logic [mis_pkg::IRQ_N-1:0] events;
  logic                     ext_mode;
  logic                     io_mode;
  logic                     tilt_mode;

  assign ext_mode  = ctrl_q[mis_pkg::CTRL_EXT_TRIG];
  assign io_mode   = ctrl_q[mis_pkg::CTRL_IO_MODE];
  assign tilt_mode = ctrl_q[mis_pkg::CTRL_TILT];

  // ---------------- trigger and busy ----------------
  logic trig_req;
  logic start_ok;

  // high-volt input acts on level, low-volt input only on its rising edge
  assign trig_req = deb[mis_pkg::IN_TRIG_HV]
                  | (deb[mis_pkg::IN_TRIG_LV] & ~deb_prev_q[mis_pkg::IN_TRIG_LV]);
  assign start_ok = trig_req & ext_mode & ~capture_in_progress;

  // start pulse to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= start_ok;
    end
  end

  // busy spans start through capture; a start in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_in_progress <= 1'b0;
    end else if (start_ok) begin
      capture_in_progress <= 1'b1;
    end else if (capture_done) begin
      capture_in_progress <= 1'b0;
    end
  end

  // ---------------- strobe and result ----------------
  mis_strobe_if sif ();

  assign sif.start    = judge_done;
  assign sif.pass_in  = judge_ok;
  assign sif.delay_ms = delay_q;
  assign sif.width_ms = width_q;

  mis_strobe_gen #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_strobe (
    .aclk    (aclk),
    .aresetn (aresetn),
    .sif     (sif.gen)
  );

  // re-register so the pins come from flops in this module
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      judgment_strobe <= 1'b0;
      judgment_pass   <= 1'b0;
    end else begin
      judgment_strobe <= sif.strobe;
      judgment_pass   <= sif.pass_out;
    end
  end

  // ---------------- hold and reporting ----------------
  logic hold_eff;
  logic held_sent_q;

  // hold only counts in internal mode
  assign hold_eff  = deb[mis_pkg::IN_HOLD] & ~ext_mode;

  // measuring never stops; only the report path is gated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      report_send        <= 1'b0;
      report_resend_held <= 1'b0;
      held_sent_q        <= 1'b0;
    end else begin
      report_send        <= result_valid & ~hold_eff;
      report_resend_held <= hold_eff & io_mode & ~held_sent_q;
      if (!hold_eff) begin
        held_sent_q <= 1'b0;
      end else if (io_mode) begin
        held_sent_q <= 1'b1;
      end
    end
  end

  // ---------------- zero set and laser ----------------
  logic zero_rise;

  assign zero_rise = deb[mis_pkg::IN_ZERO] & ~deb_prev_q[mis_pkg::IN_ZERO];

  // zero input means origin normally, criterion swap in offset tilt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      origin_set       <= 1'b0;
      criterion_toggle <= 1'b0;
      criterion_sel    <= 1'b0;
    end else begin
      origin_set       <= zero_rise & ~tilt_mode;
      criterion_toggle <= zero_rise & tilt_mode;
      if (zero_rise && tilt_mode) begin
        criterion_sel <= ~criterion_sel;
      end
    end
  end

  // laser follows the filtered contact state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      laser_enable <= 1'b0;
    end else begin
      laser_enable <= deb[mis_pkg::IN_LASER];
    end
  end

  // ---------------- interrupt events ----------------
  always_comb begin
    events                       = '0;
    events[mis_pkg::EV_START]    = start_ok;
    events[mis_pkg::EV_IGNORED]  = trig_req & ~start_ok;
    events[mis_pkg::EV_JUDGED]   = judge_done;
    events[mis_pkg::EV_CAPTURED] = capture_done;
    events[mis_pkg::EV_ZERO]     = zero_rise;
  end

  // ---------------- axi4-lite write path ----------------
  logic       aw_hs;
  logic       w_hs;
  logic       aw_got_q;
  logic       w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       commit;
  logic       wr_hit;
  logic [9:0] wr_ms;

  assign aw_hs  = s_axi_awvalid & s_axi_awready;
  assign w_hs   = s_axi_wvalid & s_axi_wready;
  assign commit = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign wr_hit = (awaddr_q == mis_pkg::OFS_CTRL)  | (awaddr_q == mis_pkg::OFS_DELAY)
                | (awaddr_q == mis_pkg::OFS_WIDTH) | (awaddr_q == mis_pkg::OFS_ISTAT)
                | (awaddr_q == mis_pkg::OFS_IMASK);

  // millisecond settings are clamped into 1..999
  always_comb begin
    wr_ms = wdata_q[9:0];
    if (wdata_q[31:10] != '0 || wr_ms > mis_pkg::MS_MAX) begin
      wr_ms = mis_pkg::MS_MAX;
    end else if (wr_ms < mis_pkg::MS_MIN) begin
      wr_ms = mis_pkg::MS_MIN;
    end
  end

  // address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (commit) begin
        aw_got_q <= 1'b0;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (commit) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // ready is re-offered only once the channel has drained
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~(aw_got_q | aw_hs) | commit;
      s_axi_wready  <= ~(w_got_q | w_hs) | commit;
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mis_pkg::RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? mis_pkg::RESP_OKAY : mis_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers; byte lane 0 carries all control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= mis_pkg::CTRL_RST;
      delay_q <= mis_pkg::DELAY_RST;
      width_q <= mis_pkg::WIDTH_RST;
      imask_q <= '0;
    end else if (commit) begin
      if (awaddr_q == mis_pkg::OFS_CTRL && wstrb_q[0]) begin
        ctrl_q <= wdata_q[2:0];
      end
      if (awaddr_q == mis_pkg::OFS_DELAY && wstrb_q[1:0] == 2'h3) begin
        delay_q <= wr_ms;
      end
      if (awaddr_q == mis_pkg::OFS_WIDTH && wstrb_q[1:0] == 2'h3) begin
        width_q <= wr_ms;
      end
      if (awaddr_q == mis_pkg::OFS_IMASK && wstrb_q[0]) begin
        imask_q <= wdata_q[mis_pkg::IRQ_N-1:0];
      end
    end
  end

  // sticky status; a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      istat_q <= '0;
    end else if (commit && awaddr_q == mis_pkg::OFS_ISTAT && wstrb_q[0]) begin
      istat_q <= (istat_q & ~wdata_q[mis_pkg::IRQ_N-1:0]) | events;
    end else begin
      istat_q <= istat_q | events;
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat_q & imask_q);
    end
  end

  // ---------------- axi4-lite read path ----------------
  logic        ar_hs;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign ar_hs = s_axi_arvalid & s_axi_arready;

  // read mux; reserved bits read zero
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      mis_pkg::OFS_CTRL:   rd_val[2:0] = ctrl_q;
      mis_pkg::OFS_DELAY:  rd_val[9:0] = delay_q;
      mis_pkg::OFS_WIDTH:  rd_val[9:0] = width_q;
      mis_pkg::OFS_STATUS: rd_val[6:0] = {criterion_sel, laser_enable, hold_eff, sif.active,
                                          judgment_pass, judgment_strobe, capture_in_progress};
      mis_pkg::OFS_ISTAT:  rd_val[mis_pkg::IRQ_N-1:0] = istat_q;
      mis_pkg::OFS_IMASK:  rd_val[mis_pkg::IRQ_N-1:0] = imask_q;
      default:             rd_hit = 1'b0;
    endcase
  end

  // single outstanding read, answered the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= mis_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? mis_pkg::RESP_OKAY : mis_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : measurement_io_sequencer
`default_nettype wire

// ===== design/mis_debounce.sv
// two-flop synchroniser and stability filter, one lane per input
`timescale 1ns/1ps
`default_nettype none
module mis_debounce #(
  parameter int W      = 5,
  parameter int CYCLES = 10000
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] clean
);
  localparam int CW = $clog2(CYCLES + 1);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic          meta_q;
      logic          sync_q;
      logic [CW-1:0] cnt_q;
      // first flop feeds only the second
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= raw[i];
          sync_q <= meta_q;
        end
      end
      // level must hold for the whole window before it is believed
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q    <= '0;
          clean[i] <= 1'b0;
        end else if (sync_q == clean[i]) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
          cnt_q    <= '0;
          clean[i] <= sync_q;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate
endmodule : mis_debounce
`default_nettype wire

// ===== design/mis_pkg.sv
// constants shared by the measurement i/o sequencer modules
package mis_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MS_NS          = 1000000;
  localparam int CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_NS    = 100000;
  localparam int DEBOUNCE_CYC   = DEBOUNCE_NS / CLK_PERIOD_NS;

  // strobe setting range in milliseconds
  localparam int         MS_W       = 10;
  localparam logic [9:0] MS_MIN     = 10'h001;
  localparam logic [9:0] MS_MAX     = 10'h3E7;
  localparam logic [9:0] DELAY_RST  = 10'h001;
  localparam logic [9:0] WIDTH_RST  = 10'h001;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DELAY  = 8'h04;
  localparam logic [7:0] OFS_WIDTH  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ISTAT  = 8'h10;
  localparam logic [7:0] OFS_IMASK  = 8'h14;

  // control fields
  localparam int CTRL_EXT_TRIG = 0;
  localparam int CTRL_IO_MODE  = 1;
  localparam int CTRL_TILT     = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // interrupt event bits
  localparam int IRQ_N         = 5;
  localparam int EV_START      = 0;
  localparam int EV_IGNORED    = 1;
  localparam int EV_JUDGED     = 2;
  localparam int EV_CAPTURED   = 3;
  localparam int EV_ZERO       = 4;

  // debounced input indices
  localparam int IN_N          = 5;
  localparam int IN_TRIG_HV    = 0;
  localparam int IN_TRIG_LV    = 1;
  localparam int IN_HOLD       = 2;
  localparam int IN_ZERO       = 3;
  localparam int IN_LASER      = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MIS_ST_IDLE  = 2'b00,
    MIS_ST_DELAY = 2'b01,
    MIS_ST_PULSE = 2'b10
  } mis_strobe_state_e;
endpackage : mis_pkg

// ===== design/mis_strobe_gen.sv
// delayed judgment strobe with programmable delay and width in ms
`timescale 1ns/1ps
`default_nettype none
module mis_strobe_gen #(
  parameter int CYC_PER_MS = mis_pkg::CYC_PER_MS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  mis_strobe_if.gen sif
);
  localparam int TW = $clog2(CYC_PER_MS + 1);

  mis_pkg::mis_strobe_state_e state_q;
  logic [TW-1:0]              tick_q;
  logic [9:0]                 ms_q;
  logic [9:0]                 width_q;
  logic                       tick;

  assign tick = (tick_q == TW'(CYC_PER_MS - 1));

  // result is latched at judgment so it settles before the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sif.pass_out <= 1'b0;
    end else if (sif.start) begin
      sif.pass_out <= sif.pass_in;
    end
  end

  // a new judgment restarts the sequence; late strobes would mislabel results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= mis_pkg::MIS_ST_IDLE;
      tick_q     <= '0;
      ms_q       <= '0;
      width_q    <= '0;
      sif.strobe <= 1'b0;
    end else if (sif.start) begin
      state_q    <= mis_pkg::MIS_ST_DELAY;
      tick_q     <= '0;
      ms_q       <= sif.delay_ms;
      width_q    <= sif.width_ms;
      sif.strobe <= 1'b0;
    end else begin
      tick_q <= (tick || state_q == mis_pkg::MIS_ST_IDLE) ? '0 : tick_q + 1'b1;
      case (state_q)
        mis_pkg::MIS_ST_DELAY: begin
          if (tick) begin
            if (ms_q <= mis_pkg::MS_MIN) begin
              state_q    <= mis_pkg::MIS_ST_PULSE;
              ms_q       <= width_q;
              sif.strobe <= 1'b1;
            end else begin
              ms_q <= ms_q - 1'b1;
            end
          end
        end
        mis_pkg::MIS_ST_PULSE: begin
          if (tick) begin
            if (ms_q <= mis_pkg::MS_MIN) begin
              state_q    <= mis_pkg::MIS_ST_IDLE;
              sif.strobe <= 1'b0;
            end else begin
              ms_q <= ms_q - 1'b1;
            end
          end
        end
        default: begin
          state_q <= mis_pkg::MIS_ST_IDLE;
        end
      endcase
    end
  end

  assign sif.active = (state_q != mis_pkg::MIS_ST_IDLE);
endmodule : mis_strobe_gen
`default_nettype wire

// ===== design/mis_strobe_if.sv
// carrier between the sequencer and its strobe generator
`timescale 1ns/1ps
`default_nettype none
interface mis_strobe_if;
  logic       start;
  logic       pass_in;
  logic [9:0] delay_ms;
  logic [9:0] width_ms;
  logic       strobe;
  logic       pass_out;
  logic       active;

  modport ctrl (output start, output pass_in, output delay_ms, output width_ms,
                input strobe, input pass_out, input active);
  modport gen  (input start, input pass_in, input delay_ms, input width_ms,
                output strobe, output pass_out, output active);
endinterface : mis_strobe_if
`default_nettype wire

// ===== tb/mis_checker_sva.sv
// assertions on the discrete side of the measurement i/o sequencer
`timescale 1ns/1ps
`default_nettype none
module mis_checker_sva #(
  parameter int CYC_PER_MS = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic meas_start,
  input wire logic capture_in_progress,
  input wire logic capture_done,
  input wire logic judge_done,
  input wire logic judge_ok,
  input wire logic judgment_pass,
  input wire logic judgment_strobe,
  input wire logic laser_pair_shorted,
  input wire logic laser_enable,
  input wire logic criterion_toggle,
  input wire logic criterion_sel,
  input wire logic report_send,
  input wire logic result_valid
);
  int hi_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // length of the present strobe pulse, restarted by reset
  always_ff @(posedge aclk) begin
    hi_q <= (aresetn && judgment_strobe) ? hi_q + 1 : 0;
  end
  sequence strobe_quiet;
    !judgment_strobe [*8];
  endsequence
  sequence shorted_long;
    laser_pair_shorted [*8] ##1 laser_pair_shorted [*8];
  endsequence
  busy_on_start_a: assert property (meas_start |-> capture_in_progress)
    else $error("busy low at accepted start");
  busy_release_a: assert property (capture_in_progress && capture_done |=> !capture_in_progress || meas_start)
    else $error("busy held after capture end");
  start_refused_a: assert property (meas_start |-> !$past(capture_in_progress) || $past(capture_done))
    else $error("start accepted while busy");
  pass_level_a: assert property (judge_done |-> ##2 judgment_pass == $past(judge_ok, 2))
    else $error("result level wrong");
  strobe_delay_a: assert property (judge_done |-> ##2 strobe_quiet)
    else $error("strobe too early");
  strobe_width_a: assert property ($fell(judgment_strobe) |-> hi_q >= CYC_PER_MS || $past(judge_done, 2))
    else $error("strobe too short");
  laser_follow_a: assert property (shorted_long |=> laser_enable)
    else $error("laser not enabled");
  toggle_flip_a: assert property (criterion_toggle |-> ##1 criterion_sel != $past(criterion_sel, 2))
    else $error("criterion did not toggle");
  report_cause_a: assert property (report_send |-> $past(result_valid))
    else $error("report without result");
endmodule : mis_checker_sva
`default_nettype wire

// ===== tb/mis_core_model.sv
// behavioural measurement core: capture, judgment and result pulses
`timescale 1ns/1ps
`default_nettype none
module mis_core_model #(
  parameter int LAT = 30
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic meas_start,
  input  wire logic kick,
  input  wire logic ok_in,
  output logic      capture_done,
  output logic      judge_done,
  output logic      judge_ok,
  output logic      result_valid
);
  int cnt_q;
  // capture ends lat+1 cycles after a start; judgment and result follow one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q        <= 0;
      capture_done <= 1'b0;
      judge_done   <= 1'b0;
      result_valid <= 1'b0;
      judge_ok     <= 1'b0;
    end else begin
      cnt_q        <= (meas_start || kick) ? LAT : ((cnt_q > 0) ? cnt_q - 1 : 0);
      capture_done <= (cnt_q == 1);
      judge_done   <= capture_done;
      result_valid <= capture_done;
      judge_ok     <= capture_done ? ok_in : ~judge_ok;  // flips when idle so a late sample shows
    end
  end
endmodule : mis_core_model
`default_nettype wire

// ===== tb/test_measurement_io_sequencer.sv
// self-checking bench of the measurement i/o sequencer
`timescale 1ns/1ps
`default_nettype none
module test_measurement_io_sequencer;
  localparam int CPM = 10;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, strobe_d;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, seed;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        start_in_high_volt, start_in_low_volt, hold_in, zero_in, laser_pair_shorted, kick, ok_in;
  logic        judgment_strobe, judgment_pass, capture_in_progress, capture_done, judge_done, judge_ok;
  logic        result_valid, meas_start, laser_enable, origin_set, criterion_toggle, criterion_sel;
  logic        report_send, report_resend_held, irq;
  int          miscompares = 0, comparisons = 0, cyc = 0, nstart = 0, nrep = 0, nres = 0, norig = 0;
  int          ntog = 0, t_j = 0, t_r = 0, t_f = 0, n0;

  measurement_io_sequencer #(.CYC_PER_MS(CPM), .DEBOUNCE_CYC(4)) measurement_io_sequencer_inst (.*);
  mis_core_model mis_core_model_inst (.*);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // settings outside 1..999 land on the nearest bound
  function automatic logic [31:0] clamp(input logic [31:0] v);
    return (v < 32'h1) ? 32'h1 : ((v > 32'h3E7) ? 32'h3E7 : v);
  endfunction : clamp
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // both channels offered together, each dropped at its own handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
  endtask : axi_rd
  task automatic pulse_kick();
    kick <= 1'b1;
    wt(1);
    kick <= 1'b0;
    wt(40);
  endtask : pulse_kick
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // event counters and strobe timestamps; the watchdog cuts a hang short
  always @(posedge aclk) begin
    cyc      <= cyc + 1;
    strobe_d <= judgment_strobe;
    nstart   <= nstart + meas_start;
    nrep     <= nrep + report_send;
    nres     <= nres + report_resend_held;
    norig    <= norig + origin_set;
    ntog     <= ntog + criterion_toggle;
    if (judge_done) t_j <= cyc;
    if (judgment_strobe && !strobe_d) t_r <= cyc;
    if (!judgment_strobe && strobe_d) t_f <= cyc;
    if (cyc == 6000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, strobe_d} = '0;
    {start_in_high_volt, start_in_low_volt, hold_in, zero_in, laser_pair_shorted, kick, ok_in} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    seed = 8'h4B;
    wt(8);
    aresetn <= 1'b1;
    wt(2);
    axi_rd(8'h04, 32'h1, 2'h0);
    axi_wr(8'h04, 32'h3E8, 2'h0);
    axi_rd(8'h04, clamp(32'h3E8), 2'h0);
    axi_wr(8'h08, 32'h0, 2'h0);
    axi_rd(8'h08, clamp(32'h0), 2'h0);
    axi_wr(8'h18, 32'h1, mis_pkg::RESP_SLVERR);
    axi_rd(8'h18, 32'h0, mis_pkg::RESP_SLVERR);
    // internal mode: the trigger edge is only flagged as ignored
    start_in_low_volt <= 1'b1;
    wt(20);
    check(nstart, 0);
    axi_rd(8'h10, 32'h2, 2'h0);
    axi_wr(8'h10, 32'h1F, 2'h0);
    axi_wr(8'h00, 32'h1, 2'h0);
    axi_wr(8'h04, 32'h2, 2'h0);
    axi_wr(8'h08, 32'h3, 2'h0);
    axi_wr(8'h14, 32'h1, 2'h0);
    check(nstart, 0);
    // random verdicts; a second edge lands while busy
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      ok_in <= seed[0];
      start_in_low_volt <= 1'b0;
      wt(10);
      start_in_low_volt <= 1'b1;
      wt(14);
      check(irq, 1'b1);
      start_in_low_volt <= 1'b0;
      wt(6);
      start_in_low_volt <= 1'b1;
      wt(100);
      check(nstart, i + 1);
      check(judgment_pass, seed[0]);
      check(t_r - t_j, 2 * CPM + 2);
      check(t_f - t_r, 3 * CPM);
      axi_wr(8'h10, 32'h1F, 2'h0);
      wt(2);
      check(irq, 1'b0);
    end
    start_in_high_volt <= 1'b1;
    wt(14);
    start_in_high_volt <= 1'b0;
    wt(60);
    check(nstart, 4);
    // hold: ignored in external mode, changes only reporting in internal mode
    hold_in <= 1'b1;
    wt(12);
    n0 = nrep;
    pulse_kick();
    check(nrep - n0, 1);
    hold_in <= 1'b0;
    wt(10);
    axi_wr(8'h00, 32'h2, 2'h0);
    hold_in <= 1'b1;
    wt(12);
    pulse_kick();
    check(nres, 1);
    hold_in <= 1'b0;
    axi_wr(8'h00, 32'h0, 2'h0);
    wt(10);
    hold_in <= 1'b1;
    ok_in <= ~seed[0];
    wt(12);
    pulse_kick();
    check(nrep - n0, 1);
    check(nres, 1);
    check(judgment_pass, !seed[0]);
    zero_in <= 1'b1;
    wt(12);
    check(norig, 1);
    zero_in <= 1'b0;
    axi_wr(8'h00, 32'h4, 2'h0);
    wt(10);
    zero_in <= 1'b1;
    laser_pair_shorted <= 1'b1;
    wt(20);
    check(ntog, 1);
    check(laser_enable, 1'b1);
    laser_pair_shorted <= 1'b0;
    wt(20);
    check(laser_enable, 1'b0);
    test_done();
  end
endmodule : test_measurement_io_sequencer

bind measurement_io_sequencer mis_checker_sva #(.CYC_PER_MS(CYC_PER_MS)) mis_checker_sva_inst (.*);
`default_nettype wire
